// File: ksd_defs.svh
// Register offsets, field positions, reset values and address constants.
`ifndef KSD_DEFS_SVH
`define KSD_DEFS_SVH
`define KSD_OFS_CTRL 8'h00
`define KSD_OFS_STAT 8'h04
`define KSD_OFS_TIDX 8'h08
`define KSD_OFS_THI 8'h0C
`define KSD_OFS_TLO0 8'h10
`define KSD_OFS_TLO1 8'h14
`define KSD_OFS_TCMD 8'h18
`define KSD_CTRL_WIDE 0
`define KSD_CTRL_ERRLVL 1
`define KSD_CTRL_EXCLVL 2
`define KSD_CTRL_PRIV 3
`define KSD_CTRL_DIRCA 5
`define KSD_CTRL_SPID 8
`define KSD_CTRL_RST 32'h00000002
`define KSD_CDIR_BASE 32'h80000000
`define KSD_UDIR_BASE 32'hA0000000
`define KSD_RSVD_TAG 10'h3FC
`define KSD_CA_UNCACHED 3'h2
`endif

// File: ksd_pkg.sv
// Types shared by the kernel segment decoder.
`default_nettype none
package ksd_pkg;
    typedef enum logic [3:0] {
        SEG_NONE  = 4'h0,
        SEG_USEG  = 4'h1,
        SEG_CDIR  = 4'h2,
        SEG_UDIR  = 4'h3,
        SEG_SSEG  = 4'h4,
        SEG_MKRN  = 4'h5,
        SEG_RSVD  = 4'h6,
        SEG_XUSEG = 4'h7,
        SEG_XSSEG = 4'h8,
        SEG_XPHYS = 4'h9,
        SEG_XKSEG = 4'hA
    } ksd_seg_t;
    typedef struct packed {
        logic        valid;
        ksd_seg_t    seg;
        logic        mapped;
        logic        err;
        logic        miss;
        logic        inv;
        logic [2:0]  cattr;
        logic [35:0] paddr;
    } ksd_rsp_t;
    typedef struct packed {
        logic [1:0]  region;
        logic [26:0] vpn2;
        logic        glob;
        logic [7:0]  spid;
    } ksd_tag_t;
    typedef struct packed {
        logic        v;
        logic [2:0]  c;
        logic [23:0] pfn;
    } ksd_lo_t;
endpackage : ksd_pkg
`default_nettype wire

// File: ksd_decoder.sv
// Kernel segment decoder with translation buffer and APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "ksd_defs.svh"
module ksd_decoder #(
    parameter int TLB_ENTRIES = 48
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          req_valid,
    input  wire logic [63:0]   req_vaddr,
    output var ksd_pkg::ksd_rsp_t rsp
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    generate
        if (TLB_ENTRIES < 1 || TLB_ENTRIES > 63)
        begin : g_bad
            $error("TLB_ENTRIES must lie between 1 and 63.");
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0]       ctrl_r;
    logic [5:0]        idx_r;
    logic [29:0]       hi_r;
    ksd_pkg::ksd_lo_t  lo0_r;
    ksd_pkg::ksd_lo_t  lo1_r;
    logic [TLB_ENTRIES-1:0] used_r;
    ksd_pkg::ksd_tag_t ent_tag [TLB_ENTRIES];
    ksd_pkg::ksd_lo_t  ent_lo0 [TLB_ENTRIES];
    ksd_pkg::ksd_lo_t  ent_lo1 [TLB_ENTRIES];

    wire        wide     = ctrl_r[`KSD_CTRL_WIDE];
    wire        errlvl   = ctrl_r[`KSD_CTRL_ERRLVL];
    wire        exclvl   = ctrl_r[`KSD_CTRL_EXCLVL];
    wire [1:0]  priv     = ctrl_r[`KSD_CTRL_PRIV +: 2];
    wire [2:0]  dir_ca   = ctrl_r[`KSD_CTRL_DIRCA +: 3];
    wire [7:0]  space_id = ctrl_r[`KSD_CTRL_SPID +: 8];

    wire setup   = psel & ~penable;
    wire wr_acc  = psel & penable & pready & pwrite;
    wire a_ctrl  = paddr == `KSD_OFS_CTRL;
    wire a_stat  = paddr == `KSD_OFS_STAT;
    wire a_tidx  = paddr == `KSD_OFS_TIDX;
    wire a_thi   = paddr == `KSD_OFS_THI;
    wire a_tlo0  = paddr == `KSD_OFS_TLO0;
    wire a_tlo1  = paddr == `KSD_OFS_TLO1;
    wire a_tcmd  = paddr == `KSD_OFS_TCMD;
    wire a_ok    = a_ctrl | a_stat | a_tidx | a_thi | a_tlo0 | a_tlo1
                 | a_tcmd;
    wire idx_ok  = {1'b0, idx_r} < 7'(TLB_ENTRIES);
    wire tlb_wr  = wr_acc & a_tcmd & idx_ok;

    wire [31:0] stat_w = {20'h00000, rsp.cattr, rsp.inv, rsp.miss,
                          rsp.err, rsp.mapped, rsp.seg, rsp.valid};
    wire [31:0] rd_mux = a_ctrl ? ctrl_r
                       : a_stat ? stat_w
                       : a_tidx ? {26'h0000000, idx_r}
                       : a_thi  ? {2'h0, hi_r}
                       : a_tlo0 ? {4'h0, lo0_r}
                       : a_tlo1 ? {4'h0, lo1_r}
                       : 32'h00000000;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~a_ok;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_r <= `KSD_CTRL_RST;
            idx_r  <= 6'h00;
            hi_r   <= 30'h00000000;
            lo0_r  <= '0;
            lo1_r  <= '0;
        end
        else if (wr_acc)
        begin
            if (a_ctrl) ctrl_r <= {16'h0000, pwdata[15:0]};
            if (a_tidx) idx_r  <= pwdata[5:0];
            if (a_thi)  hi_r   <= pwdata[29:0];
            if (a_tlo0) lo0_r  <= pwdata[27:0];
            if (a_tlo1) lo1_r  <= pwdata[27:0];
        end
    end

    // ****************************************************************
    // Translation buffer
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            used_r <= '0;
        else if (tlb_wr)
            used_r[idx_r] <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (tlb_wr)
        begin
            ent_tag[idx_r] <= {hi_r[28:27], hi_r[26:0], hi_r[29], space_id};
            ent_lo0[idx_r] <= lo0_r;
            ent_lo1[idx_r] <= lo1_r;
        end
    end

    logic [TLB_ENTRIES-1:0] hit_vec;
    genvar gi;
    generate
        for (gi = 0; gi < TLB_ENTRIES; gi++)
        begin : g_cmp
            assign hit_vec[gi] = used_r[gi]
                & ent_tag[gi].region == req_vaddr[63:62]
                & ent_tag[gi].vpn2 == req_vaddr[39:13]
                & (ent_tag[gi].glob | ent_tag[gi].spid == space_id);
        end
    endgenerate

    ksd_pkg::ksd_lo_t hit_lo;
    always_comb
    begin
        hit_lo = '0;
        for (int i = TLB_ENTRIES - 1; i >= 0; i--)
        begin
            if (hit_vec[i])
                hit_lo = req_vaddr[12] ? ent_lo1[i] : ent_lo0[i];
        end
    end
    wire tlb_hit = |hit_vec;

    // ****************************************************************
    // Segment decode
    // ****************************************************************
    wire kernel  = priv == 2'b00 | exclvl | errlvl;
    wire sext_ok = req_vaddr[63:32] == {32{req_vaddr[31]}};
    wire compat  = wide & (&req_vaddr[63:31]);
    wire rsvd    = req_vaddr[31:22] == `KSD_RSVD_TAG;
    wire hi_zero = req_vaddr[61:40] == 22'h000000;
    wire [31:0] cdir_off = req_vaddr[31:0] - `KSD_CDIR_BASE;
    wire [31:0] k1_off = req_vaddr[31:0] - `KSD_UDIR_BASE;

    ksd_pkg::ksd_seg_t d_seg;
    logic        d_map;
    logic        d_err;
    logic [2:0]  d_ca;
    logic [35:0] d_pa;

    always_comb
    begin
        d_seg = ksd_pkg::SEG_NONE;
        d_map = 1'b0;
        d_err = 1'b0;
        d_ca  = `KSD_CA_UNCACHED;
        d_pa  = 36'h000000000;
        if (!kernel)
            d_err = 1'b1;
        else if (!wide & !sext_ok)
            d_err = 1'b1;
        else if (!wide | compat)
        begin
            unique casez (req_vaddr[31:29])
                3'b0??:
                begin
                    d_seg = ksd_pkg::SEG_USEG;
                    d_map = ~errlvl;
                    d_pa  = {5'h00, req_vaddr[30:0]};
                end
                3'b100:
                begin
                    d_seg = ksd_pkg::SEG_CDIR;
                    d_pa  = {4'h0, cdir_off};
                    d_ca  = dir_ca;
                end
                3'b101:
                begin
                    d_seg = ksd_pkg::SEG_UDIR;
                    d_pa  = {4'h0, k1_off};
                end
                3'b110:
                begin
                    d_seg = ksd_pkg::SEG_SSEG;
                    d_map = 1'b1;
                end
                3'b111:
                begin
                    d_seg = rsvd ? ksd_pkg::SEG_RSVD
                                 : ksd_pkg::SEG_MKRN;
                    d_map = ~rsvd;
                    d_pa  = {4'h0, req_vaddr[31:0]};
                end
            endcase
        end
        else
        begin
            unique case (req_vaddr[63:62])
                2'b00:
                begin
                    d_seg = ksd_pkg::SEG_XUSEG;
                    d_map = ~errlvl;
                    d_err = errlvl ? req_vaddr[61:31] != 31'h00000000
                                : ~hi_zero;
                    d_pa  = {5'h00, req_vaddr[30:0]};
                end
                2'b01:
                begin
                    d_seg = ksd_pkg::SEG_XSSEG;
                    d_map = 1'b1;
                    d_err = ~hi_zero;
                end
                2'b10:
                begin
                    d_seg = ksd_pkg::SEG_XPHYS;
                    d_err = (|req_vaddr[58:36]) | req_vaddr[61];
                    d_pa  = req_vaddr[35:0];
                    d_ca  = req_vaddr[61:59];
                end
                2'b11:
                begin
                    d_seg = ksd_pkg::SEG_XKSEG;
                    d_map = 1'b1;
                    d_err = ~hi_zero | (&req_vaddr[39:31]);
                end
            endcase
        end
        if (d_map)
        begin
            d_pa = {hit_lo.pfn, req_vaddr[11:0]};
            d_ca = hit_lo.c;
        end
    end

    // ****************************************************************
    // Response register
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rsp <= '0;
        else
        begin
            rsp.valid  <= req_valid;
            rsp.seg    <= d_seg;
            rsp.mapped <= d_map & ~d_err;
            rsp.err    <= d_err;
            rsp.miss   <= d_map & ~d_err & ~tlb_hit;
            rsp.inv    <= d_map & ~d_err & tlb_hit & ~hit_lo.v;
            rsp.cattr  <= d_err ? `KSD_CA_UNCACHED : d_ca;
            rsp.paddr  <= d_err ? 36'h000000000 : d_pa;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire k32 = req_valid & kernel & ~wide & sext_ok;
    wire kph = req_valid & kernel & wide & req_vaddr[63:62] == 2'b10;

    property p_mode;
        req_valid & ~kernel |=> rsp.valid & rsp.err;
    endproperty
    a_mode: assert property (p_mode) else $error("User access passed.");

    property p_useg;
        k32 & ~errlvl & ~req_vaddr[31] |=> rsp.mapped
            & rsp.seg == ksd_pkg::SEG_USEG;
    endproperty
    a_useg: assert property (p_useg) else $error("User not mapped.");

    property p_elvl;
        k32 & errlvl & ~req_vaddr[31] |=> ~rsp.mapped
            & rsp.cattr == `KSD_CA_UNCACHED
            & rsp.paddr == {5'h00, $past(req_vaddr[30:0])};
    endproperty
    a_elvl: assert property (p_elvl) else $error("Error level wrong.");

    property p_cdir;
        k32 & req_vaddr[31:29] == 3'b100 |=> ~rsp.mapped
            & rsp.cattr == $past(dir_ca)
            & rsp.paddr == {7'h00, $past(req_vaddr[28:0])};
    endproperty
    a_cdir: assert property (p_cdir) else $error("Cached seg wrong.");

    property p_k1;
        k32 & req_vaddr[31:29] == 3'b101 |=> ~rsp.mapped
            & rsp.cattr == `KSD_CA_UNCACHED
            & rsp.paddr == {7'h00, $past(req_vaddr[28:0])};
    endproperty
    a_k1: assert property (p_k1) else $error("Uncached direct wrong.");

    property p_rsvd;
        k32 & rsvd |=> ~rsp.mapped & rsp.seg == ksd_pkg::SEG_RSVD;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("Hole was mapped.");

    property p_sext;
        req_valid & kernel & ~wide & ~sext_ok |=> rsp.err;
    endproperty
    a_sext: assert property (p_sext) else $error("Bad sign passed.");

    property p_phys_err;
        kph & (|req_vaddr[58:36]) |=> rsp.err & ~rsp.mapped;
    endproperty
    a_phys_err: assert property (p_phys_err) else $error("No error.");

    property p_phys;
        kph & ~(|req_vaddr[58:36]) & ~req_vaddr[61] |=> ~rsp.err
            & rsp.paddr == $past(req_vaddr[35:0])
            & rsp.cattr == $past(req_vaddr[61:59]);
    endproperty
    a_phys: assert property (p_phys) else $error("Window wrong.");

    property p_apb;
        setup |=> pready ##1 ~pready;
    endproperty
    a_apb: assert property (p_apb) else $error("Ready not one cycle.");

    c_cdir:   cover property (k32 & req_vaddr[31:29] == 3'b100);
    c_phys:   cover property (kph ##1 ~rsp.err);
    c_hit:    cover property (rsp.mapped & ~rsp.miss);
    c_compat: cover property (req_valid & kernel & compat);

endmodule : ksd_decoder
`default_nettype wire

// File: ksd_agen_model.sv
// Address generation stage model that issues decode requests.
`timescale 1ns/1ps
`default_nettype none
module ksd_agen_model (
    input  wire logic              clk,
    output logic                   req_valid,
    output logic [63:0]            req_vaddr,
    input  wire ksd_pkg::ksd_rsp_t rsp
);
    initial
    begin
        req_valid = 1'b0;
        req_vaddr = 64'h0;
    end

    // Issues one request and returns the answer of the following cycle.
    // The address line is inverted when idle so stale values cannot match.
    task automatic send(input logic [63:0] va,
                        output ksd_pkg::ksd_rsp_t r);
        @(posedge clk);
        req_valid <= 1'b1;
        req_vaddr <= va;
        @(posedge clk);
        req_valid <= 1'b0;
        req_vaddr <= ~va;
        @(negedge clk);
        r = rsp;
    endtask : send
endmodule : ksd_agen_model
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the kernel segment decoder.
`timescale 1ns/1ps
`default_nettype none
`include "ksd_defs.svh"
module tb_top;
    logic              clk;
    logic              nrst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              req_valid;
    logic [63:0]       req_vaddr;
    ksd_pkg::ksd_rsp_t rsp;
    ksd_pkg::ksd_rsp_t got;
    logic [31:0]       rd;
    logic              er;
    int                error_cnt;
    int                samples_checked;
    localparam logic [47:0] M_ALL = 48'hFFFF_FFFF_FFFF;
    localparam logic [47:0] M_MAP = 48'hFF00_0000_0000;
    localparam logic [47:0] M_ERR = 48'h867F_FFFF_FFFF;

    ksd_decoder #(.TLB_ENTRIES(48)) dut (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .rsp(rsp));
    ksd_agen_model agen (.clk(clk), .req_valid(req_valid),
        .req_vaddr(req_vaddr), .rsp(rsp));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // *****************************************************************
    // Tasks.
    // *****************************************************************
    task automatic summarize();
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %0t word %h exp %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_rsp(input logic [47:0] g, input logic [47:0] e,
                           input logic [47:0] m);
        samples_checked++;
        if ((g & m) !== (e & m))
        begin
            error_cnt++;
            $display("MISMATCH %0t rsp %h exp %h", $time, g, e);
        end
    endtask : chk_rsp

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
            error_cnt++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic ksd_pkg::ksd_rsp_t mk(ksd_pkg::ksd_seg_t s,
        logic m, logic e, logic ms, logic iv, logic [2:0] c,
        logic [35:0] pa);
        mk = '{1'b1, s, m, e, ms, iv, c, pa};
    endfunction : mk

    task automatic dec(input logic [63:0] va, input ksd_pkg::ksd_rsp_t e,
                       input logic [47:0] m);
        agen.send(va, got);
        chk_rsp(got, e, m);
    endtask : dec

    task automatic du(input logic [63:0] va, input ksd_pkg::ksd_seg_t s,
                      input logic [2:0] c, input logic [35:0] pa);
        dec(va, mk(s, 1'b0, 1'b0, 1'b0, 1'b0, c, pa), M_ALL);
    endtask : du

    task automatic dm(input logic [63:0] va, input ksd_pkg::ksd_seg_t s);
        dec(va, mk(s, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 36'h0), M_MAP);
    endtask : dm

    task automatic de(input logic [63:0] va);
        dec(va, mk(ksd_pkg::SEG_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 3'h2,
            36'h0), M_ERR);
    endtask : de

    // *****************************************************************
    // Test sequence.
    // *****************************************************************
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `KSD_OFS_CTRL, 32'h0);
        chk_word(rd, `KSD_CTRL_RST);
        du(64'h0000_0000_1234_5678, ksd_pkg::SEG_USEG, 3'h2, 36'h12345678);
        apb(1'b1, `KSD_OFS_CTRL, 32'h0000_0563);
        du(64'h0000_0000_1234_5678, ksd_pkg::SEG_XUSEG, 3'h2, 36'h12345678);
        apb(1'b1, `KSD_OFS_CTRL, 32'h0000_0560);
        dm(64'h0000_0000_7000_0000, ksd_pkg::SEG_USEG);
        du(64'hFFFF_FFFF_8000_1234, ksd_pkg::SEG_CDIR, 3'h3, 36'h1234);
        du(64'hFFFF_FFFF_BFFF_FFFC, ksd_pkg::SEG_UDIR, 3'h2,
           36'h1FFFFFFC);
        dm(64'hFFFF_FFFF_C000_0000, ksd_pkg::SEG_SSEG);
        dm(64'hFFFF_FFFF_FEFF_F000, ksd_pkg::SEG_MKRN);
        du(64'hFFFF_FFFF_FF00_0000, ksd_pkg::SEG_RSVD, 3'h2,
           36'hFF000000);
        dm(64'hFFFF_FFFF_FF40_0000, ksd_pkg::SEG_MKRN);
        de(64'h0000_0000_8000_0000);
        de(64'hFFFF_FFFF_7FFF_FFFF);
        apb(1'b1, `KSD_OFS_CTRL, 32'h0000_0570);
        de(64'hFFFF_FFFF_A000_0000);
        apb(1'b1, `KSD_OFS_CTRL, 32'h0000_0574);
        du(64'hFFFF_FFFF_A000_0000, ksd_pkg::SEG_UDIR, 3'h2, 36'h0);
        apb(1'b1, `KSD_OFS_CTRL, 32'hFFFF_0561);
        apb(1'b0, `KSD_OFS_CTRL, 32'h0);
        chk_word(rd, 32'h0000_0561);
        dm(64'h0000_00FF_FFFF_F000, ksd_pkg::SEG_XUSEG);
        de(64'h0000_0100_0000_0000);
        dm(64'h4000_0000_0000_0000, ksd_pkg::SEG_XSSEG);
        de(64'h4000_0100_0000_0000);
        for (int i = 0; i < 4; i++)
            du({2'b10, i[2:0], 23'h0, 36'hF_1234_5678}, ksd_pkg::SEG_XPHYS, i[2:0], 36'hF_1234_5678);
        for (int i = 4; i < 8; i++)
            de({2'b10, i[2:0], 59'h0});
        de(64'h8000_0010_0000_0000);
        dm(64'hC000_00FF_7FFF_F000, ksd_pkg::SEG_XKSEG);
        de(64'hC000_00FF_8000_0000);
        du(64'hFFFF_FFFF_8000_0010, ksd_pkg::SEG_CDIR, 3'h3,
           36'h10);
        du(64'hFFFF_FFFF_A000_0010, ksd_pkg::SEG_UDIR, 3'h2, 36'h10);
        dm(64'hFFFF_FFFF_C000_0000, ksd_pkg::SEG_SSEG);
        dm(64'hFFFF_FFFF_E000_0000, ksd_pkg::SEG_MKRN);
        du(64'hFFFF_FFFF_FF3F_FFFC, ksd_pkg::SEG_RSVD, 3'h2,
           36'hFF3FFFFC);
        apb(1'b1, `KSD_OFS_TIDX, 32'h0000_002F);
        apb(1'b1, `KSD_OFS_THI, 32'h1FFF_0001);
        apb(1'b1, `KSD_OFS_TLO0, 32'h0B00_0ABC);
        apb(1'b1, `KSD_OFS_TLO1, 32'h0);
        apb(1'b1, `KSD_OFS_TCMD, 32'h0);
        dec(64'hFFFF_FFFF_E000_2123, mk(ksd_pkg::SEG_MKRN, 1'b1, 1'b0,
            1'b0, 1'b0, 3'h3, 36'hABC123), M_ALL);
        dec(64'hFFFF_FFFF_E000_3123, mk(ksd_pkg::SEG_MKRN, 1'b1, 1'b0,
            1'b0, 1'b1, 3'h0, 36'h0), 48'hFF80_0000_0000);
        apb(1'b1, `KSD_OFS_CTRL, 32'h0000_0661);
        dm(64'hFFFF_FFFF_E000_2123, ksd_pkg::SEG_MKRN);
        apb(1'b0, 8'h1C, 32'h0);
        chk_word({31'h0, er}, 32'h1);
        chk_word(rd, 32'h0);
        apb(1'b0, `KSD_OFS_STAT, 32'h0);
        chk_word(rd, 32'h0000_00AE);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
